// >>> bench/sas_analog_model.sv
// Analog side: source level, hold capacitor, comparator and RC oscillator.
module sas_analog_model
#(
  parameter int RC_PERIOD = 5
)
(
  input  logic       sys_clk,
  input  logic [9:0] level,
  input  logic       sample_connect,
  input  logic [9:0] dac_code,
  output logic       comp_in,
  output logic       rc_tick
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [9:0] held = 10'h000;
  int         rc_cnt = 0;
  initial rc_tick = 1'b0;
  // The capacitor follows the source only while it is connected.
  always @(posedge sys_clk)
    if (sample_connect === 1'b1)
      held <= level;
  // Keep the trial bit when the held level reaches the trial code.
  assign comp_in = (held >= dac_code);
  // Free-running oscillator; phase is unrelated to conversion starts.
  always @(posedge sys_clk)
  begin
    rc_cnt <= (rc_cnt == RC_PERIOD - 1) ? 0 : rc_cnt + 1;
    rc_tick <= (rc_cnt == RC_PERIOD - 1);
  end
endmodule

// >>> bench/sas_seq_checker.sv
// Port-level assertions for the converter sequencer.
module sas_seq_checker
(
  input logic        sys_clk,
  input logic        rst,
  input logic        hsel,
  input logic [31:0] haddr,
  input logic [1:0]  htrans,
  input logic        hwrite,
  input logic        hready,
  input logic [9:0]  dac_code,
  input logic        sample_connect,
  input logic [3:0]  chan_sel,
  input logic        chan_valid,
  input logic        neg_ref_ext,
  input logic        pos_ref_ext,
  input logic [11:0] analog_pin_mask,
  input logic        conv_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic       wr_ph;
  logic [7:0] wr_a;
  ////////////////////////////////////////////////////////////////////////
  // Remember write address phases so a data-phase effect can be traced.
  always @(posedge sys_clk)
  begin
    wr_ph <= hsel & hready & htrans[1] & hwrite;
    wr_a  <= haddr[7:0];
  end
  ////////////////////////////////////////////////////////////////////////
  property p_mask_shape;
    ((analog_pin_mask + 12'h001) & analog_pin_mask) == 12'h000;
  endproperty
  a_mask_shape: assert property (p_mask_shape)
    else $error("pin mask is not a low run of ones");
  property p_chan_valid;
    chan_valid == (chan_sel < 4'hc);
  endproperty
  a_chan_valid: assert property (p_chan_valid)
    else $error("channel valid flag wrong");
  property p_hold_disc;
    $fell(sample_connect) |-> !sample_connect [*8];
  endproperty
  a_hold_disc: assert property (p_hold_disc)
    else $error("hold capacitor reconnected early");
  property p_sar_step;
    $changed(dac_code) |=> $stable(dac_code);
  endproperty
  a_sar_step: assert property (p_sar_step)
    else $error("trial code moved twice in a row");
  property p_irq_hold;
    $fell(conv_irq) |-> ($past(wr_ph) && $past(wr_a) == 8'h14) || $past(rst);
  endproperty
  a_irq_hold: assert property (p_irq_hold)
    else $error("interrupt dropped without a write");
  property p_irq_rise;
    $rose(conv_irq) |-> $past(!sample_connect);
  endproperty
  a_irq_rise: assert property (p_irq_rise)
    else $error("completion outside a conversion");
  property p_reset_vals;
    disable iff (1'b0) $fell(rst) |-> analog_pin_mask == 12'hfff
      && !neg_ref_ext && !pos_ref_ext && !conv_irq;
  endproperty
  a_reset_vals: assert property (p_reset_vals)
    else $error("outputs not at reset state");
  property p_ref_write;
    $changed({neg_ref_ext, pos_ref_ext}) |->
      ($past(wr_ph) && $past(wr_a) == 8'h04) || $past(rst);
  endproperty
  a_ref_write: assert property (p_ref_write)
    else $error("reference select moved without a write");
  c_done: cover property ($rose(conv_irq));
  c_start: cover property ($fell(sample_connect));
  c_reset: cover property (rst ##1 !rst);
endmodule

// >>> bench/test_sar_adc_sequencer.sv
// Self-checking testbench of the converter sequencer.
`include "sas_consts.vh"
module test_sar_adc_sequencer;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int RCP = 5;
  logic        sys_clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [9:0]  level = 10'h0;
  wire  [31:0] hrdata;
  wire  [9:0]  dac_code;
  wire  [11:0] analog_pin_mask;
  wire  [3:0]  chan_sel;
  wire         hreadyout, hresp, comp_in, rc_tick, sample_connect;
  wire         chan_valid, neg_ref_ext, pos_ref_ext, conv_irq;
  wire         hready = hreadyout;
  int          err_total = 0, check_count = 0, cyc = 0, t_fall, t_done;
  int          divs[8] = '{2, 8, 32, RCP, 4, 16, 64, RCP};
  int          acqs[8] = '{0, 2, 4, 6, 8, 12, 16, 20};
  sas_sequencer sas_sequencer_inst (.sys_clk, .rst, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .comp_in,
    .rc_tick, .dac_code, .sample_connect, .chan_sel, .chan_valid,
    .neg_ref_ext, .pos_ref_ext, .analog_pin_mask, .conv_irq);
  sas_analog_model #(.RC_PERIOD(RCP)) sas_analog_model_inst (.sys_clk,
    .level, .sample_connect, .dac_code, .comp_in, .rc_tick);
  ////////////////////////////////////////////////////////////////////////
  // Clock and a cycle count used to time conversions.
  always #50 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
    cyc <= cyc + 1;
  // Tolerance lets tick phase slip without hiding a wrong count.
  task automatic chk(input string nm, input logic [31:0] e, s,
                     input int tol = 0);
    check_count++;
    if ((s - e + tol <= 2 * tol) !== 1'b1)
    begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask
  // One single bus transfer; read data is taken at the closing edge.
  task automatic xfer(input logic w, input logic [7:0] a, d,
                      output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, d);
    xfer(1'b1, a, d, rd);
  endtask
  task automatic rdchk(input string nm, input logic [7:0] a, e);
    xfer(1'b0, a, 8'h0, rd);
    chk(nm, {24'h0, e}, rd);
  endtask
  // Mode 1 leaves at once; mode 2 starts inside the previous gap.
  task automatic conv(input logic [2:0] acq, cs, input logic rj,
                      input logic [9:0] v, input int mode);
    int dv, ex, t0, tl;
    dv = divs[cs];
    ex = (cs[1:0] == 2'h3) ? 4 : 0;
    tl = ex ? RCP : 1;
    level <= v;
    wr(`SAS_OFF_TIMING, {rj, 1'b0, acq, cs});
    wr(`SAS_OFF_IRQ, 8'h02);
    t0 = cyc;
    wr(`SAS_OFF_CTRL, 8'h0b);
    while (sample_connect !== 1'b0) @(posedge sys_clk);
    t_fall = cyc;
    level <= ~v;
    if (mode == 2)
      chk("gap", 1, t_fall - t_done >= 2 * dv);
    else
      chk("acq len", 3 + acqs[acq] * dv, t_fall - t0, 2);
    while (conv_irq !== 1'b1) @(posedge sys_clk);
    t_done = cyc;
    chk("conv len", 11 * dv + ex, t_done - t_fall, tl);
    rdchk("go done", `SAS_OFF_CTRL, 8'h09);
    rdchk("flag", `SAS_OFF_IRQ, 8'h03);
    rdchk("res hi", `SAS_OFF_RES_HIGH, rj ? {6'h0, v[9:8]} : v[9:2]);
    rdchk("res lo", `SAS_OFF_RES_LOW, rj ? v[7:0] : {v[1:0], 6'h0});
    if (mode != 1)
    begin
      repeat (2 * dv + ex + 3) @(posedge sys_clk);
      chk("resume", 1, sample_connect);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Cut a hang short well beyond the expected run length.
  initial
  begin
    repeat (30000) @(posedge sys_clk);
    err_total++;
    report_and_stop;
  end
  // Main sequence: registers, pin map, conversions, abort and reset.
  initial
  begin
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    rdchk("ctrl", `SAS_OFF_CTRL, 8'h00);
    rdchk("timing", `SAS_OFF_TIMING, 8'h00);
    wr(`SAS_OFF_REF_PORT, 8'hff);
    rdchk("refport", `SAS_OFF_REF_PORT, 8'h3f);
    chk("refs", 2'h3, {neg_ref_ext, pos_ref_ext});
    wr(`SAS_OFF_REF_PORT, 8'h20);
    @(posedge sys_clk);
    chk("refs", 2'h2, {neg_ref_ext, pos_ref_ext});
    wr(`SAS_OFF_TIMING, 8'hff);
    rdchk("timing", `SAS_OFF_TIMING, 8'hbf);
    for (int c = 0; c < 16; c++)
    begin
      wr(`SAS_OFF_REF_PORT, c[7:0]);
      @(posedge sys_clk);
      chk("mask", c < 4 ? 12'hfff : 12'hfff >> (c - 3), analog_pin_mask);
    end
    wr(`SAS_OFF_CTRL, 8'h30);
    @(posedge sys_clk);
    chk("chan 12", 0, chan_valid);
    chk("chan sel", 4'hc, chan_sel);
    chk("resp", 0, hresp);
    wr(`SAS_OFF_CTRL, 8'h03);
    rdchk("go while off", `SAS_OFF_CTRL, 8'h01);
    wr(8'h1c, 8'hff);
    rdchk("unmapped", 8'h1c, 8'h00);
    wr(`SAS_OFF_CTRL, 8'h09);
    // Codes 3 and 7 pick the RC clock, as software does for sleep.
    for (int c = 0; c < 8; c++)
      conv(3'h0, c[2:0], 1'b1, 10'h2a5 ^ 10'(c * 37), 0);
    for (int a = 1; a < 8; a++)
      conv(a[2:0], 3'h0, 1'b1, 10'h15a + 10'(a), 0);
    conv(3'h0, 3'h6, 1'b0, 10'h000, 1);
    conv(3'h0, 3'h6, 1'b0, 10'h3ff, 2);
    chk("irq", 1, conv_irq);
    wr(`SAS_OFF_IRQ, 8'h01);
    @(posedge sys_clk);
    chk("irq masked", 0, conv_irq);
    rdchk("flag kept", `SAS_OFF_IRQ, 8'h01);
    wr(`SAS_OFF_IRQ, 8'h00);
    rdchk("flag clr", `SAS_OFF_IRQ, 8'h00);
    wr(`SAS_OFF_TIMING, 8'h0e);
    level <= 10'h155;
    wr(`SAS_OFF_CTRL, 8'h0b);
    repeat (40) @(posedge sys_clk);
    rdchk("go in acq", `SAS_OFF_CTRL, 8'h0b);
    repeat (300) @(posedge sys_clk);
    rdchk("go busy", `SAS_OFF_CTRL, 8'h0b);
    wr(`SAS_OFF_CTRL, 8'h09);
    rdchk("go abort", `SAS_OFF_CTRL, 8'h09);
    rdchk("res kept", `SAS_OFF_RES_HIGH, 8'hff);
    rdchk("no flag", `SAS_OFF_IRQ, 8'h00);
    repeat (200) @(posedge sys_clk);
    wr(`SAS_OFF_CTRL, 8'h0b);
    repeat (300) @(posedge sys_clk);
    rst <= 1'b1;
    @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    rdchk("ctrl rst", `SAS_OFF_CTRL, 8'h00);
    rdchk("timing rst", `SAS_OFF_TIMING, 8'h00);
    rdchk("refport rst", `SAS_OFF_REF_PORT, 8'h00);
    rdchk("res after rst", `SAS_OFF_RES_HIGH, 8'hff);
    report_and_stop;
  end
endmodule
bind sas_sequencer sas_seq_checker sas_seq_checker_inst (.sys_clk, .rst,
  .hsel, .haddr, .htrans, .hwrite, .hready, .dac_code, .sample_connect,
  .chan_sel, .chan_valid, .neg_ref_ext, .pos_ref_ext, .analog_pin_mask,
  .conv_irq);

// >>> rtl/sas_consts.vh
// Constants of the successive-approximation converter sequencer.
`ifndef SAS_CONSTS_VH
`define SAS_CONSTS_VH

// Register byte offsets on the bus.
`define SAS_OFF_CTRL        8'h00
`define SAS_OFF_REF_PORT    8'h04
`define SAS_OFF_TIMING      8'h08
`define SAS_OFF_RES_HIGH    8'h0c
`define SAS_OFF_RES_LOW     8'h10
`define SAS_OFF_IRQ         8'h14

// Control register fields.
`define SAS_CTRL_ON_BIT     0
`define SAS_CTRL_GO_BIT     1
`define SAS_CTRL_CHS_LSB    2
`define SAS_CTRL_CHS_MSB    5

// Reference and port configuration fields.
`define SAS_NEG_REF_BIT     5
`define SAS_POS_REF_BIT     4
`define SAS_PCFG_MSB        3
`define SAS_REF_PORT_MASK   8'h3f

// Timing and format configuration fields.
`define SAS_JUSTIFY_BIT     7
`define SAS_ACQ_MSB         5
`define SAS_ACQ_LSB         3
`define SAS_CS_MSB          2
`define SAS_TIMING_MASK     8'hbf

// Interrupt register fields.
`define SAS_IRQ_FLAG_BIT    0
`define SAS_IRQ_EN_BIT      1

// Reset values.
`define SAS_RST_CTRL        8'h00
`define SAS_RST_REF_PORT    8'h00
`define SAS_RST_TIMING      8'h00

// Timing counts, in conversion bit-periods unless stated.
`define SAS_CONV_PERIODS    4'd11
`define SAS_GAP_PERIODS     2'd2
`define SAS_NUM_CHANNELS    4'd12
`define SAS_ADC_BITS        10
// One instruction cycle is four system clock periods.
`define SAS_TCY_CLOCKS      3'd4

`endif

// >>> rtl/sas_sequencer.v
// Top of the successive-approximation converter sequencer with bus slave.
//
// Decided for this implementation: the address map and the AHB-Lite register port.
`include "sas_consts.vh"

module sas_sequencer
(
  input  wire        sys_clk,
  input  wire        rst,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output wire        hresp,
  output reg  [31:0] hrdata,
  input  wire        comp_in,
  input  wire        rc_tick,
  output wire [9:0]  dac_code,
  output wire        sample_connect,
  output wire [3:0]  chan_sel,
  output wire        chan_valid,
  output wire        neg_ref_ext,
  output wire        pos_ref_ext,
  output wire [11:0] analog_pin_mask,
  output wire        conv_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.

  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_ACQ  = 4'b0010;
  localparam [3:0] ST_CONV = 4'b0100;
  localparam [3:0] ST_GAP  = 4'b1000;

  reg  [3:0] state;
  reg  [3:0] next_state;
  reg  [4:0] period_cnt;
  reg  [3:0] conv_cnt;
  reg  [9:0] sar;
  reg        converter_on;
  reg        go_done;
  reg  [3:0] channel_select;
  reg  [5:0] ref_port_cfg;
  reg  [7:0] timing_cfg;
  reg  [7:0] result_high;
  reg  [7:0] result_low;
  reg        conv_done_irq_flag;
  reg        conv_done_irq_enable;
  reg        dph_valid;
  reg        dph_write;
  reg  [7:0] dph_addr;
  wire       tad_tick;
  wire       seq_run;
  wire [2:0] acq_time_select;
  wire [2:0] conv_clock_select;
  wire       result_justify;
  wire [3:0] port_analog_config;
  wire [4:0] acq_periods;
  wire       wr_en;
  wire       abort;
  wire       done_evt;
  wire [3:0] bit_pos;

  ////////////////////////////////////////////////////////////////////////////
  // Functions.

  // Bit-periods of automatic acquisition for each code.
  function [4:0] acq_count;
    input [2:0] code;
    begin
      case (code)
        3'b111:  acq_count = 5'd20;
        3'b110:  acq_count = 5'd16;
        3'b101:  acq_count = 5'd12;
        3'b100:  acq_count = 5'd8;
        3'b011:  acq_count = 5'd6;
        3'b010:  acq_count = 5'd4;
        3'b001:  acq_count = 5'd2;
        default: acq_count = 5'd0;
      endcase
    end
  endfunction

  // Address match for a write in the data phase.
  function is_wr;
    input       en;
    input [7:0] addr;
    input [7:0] off;
    begin
      is_wr = en && (addr == off);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Field views of the configuration registers.

  assign acq_time_select    = timing_cfg[`SAS_ACQ_MSB:`SAS_ACQ_LSB];
  assign conv_clock_select  = timing_cfg[`SAS_CS_MSB:0];
  assign result_justify     = timing_cfg[`SAS_JUSTIFY_BIT];
  assign port_analog_config = ref_port_cfg[`SAS_PCFG_MSB:0];
  assign acq_periods        = acq_count(acq_time_select);

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave: zero wait states, always an OKAY response.

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign wr_en     = dph_valid && dph_write;

  // Address phase is captured when the bus is ready and the slot is active.
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      dph_valid <= 1'b0;
      dph_write <= 1'b0;
      dph_addr  <= 8'h00;
    end
    else if (hready)
    begin
      dph_valid <= hsel && htrans[1];
      dph_write <= hwrite;
      dph_addr  <= haddr[7:0];
    end
  end

  // Read mux from stored state; the data phase sees a settled value.
  // Unmapped words read zero.
  always @*
  begin
    hrdata = 32'h0000_0000;
    if (dph_valid && !dph_write)
    begin
      case (dph_addr)
        `SAS_OFF_CTRL:
          hrdata[7:0] = {2'b00, channel_select, go_done, converter_on};
        `SAS_OFF_REF_PORT:
          hrdata[7:0] = {2'b00, ref_port_cfg};
        `SAS_OFF_TIMING:
          hrdata[7:0] = timing_cfg & `SAS_TIMING_MASK;
        `SAS_OFF_RES_HIGH:
          hrdata[7:0] = result_high;
        `SAS_OFF_RES_LOW:
          hrdata[7:0] = result_low;
        `SAS_OFF_IRQ:
          hrdata[1:0] = {conv_done_irq_enable, conv_done_irq_flag};
        default:
          hrdata = 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers.

  // All control state returns to reset values, turning the converter off.
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      converter_on   <= 1'b0;
      channel_select <= 4'h0;
      ref_port_cfg   <= 6'h00;
      timing_cfg     <= `SAS_RST_TIMING;
      conv_done_irq_enable <= 1'b0;
    end
    else
    begin
      if (is_wr(wr_en, dph_addr, `SAS_OFF_CTRL))
      begin
        converter_on   <= hwdata[`SAS_CTRL_ON_BIT];
        channel_select <= hwdata[`SAS_CTRL_CHS_MSB:`SAS_CTRL_CHS_LSB];
      end
      if (is_wr(wr_en, dph_addr, `SAS_OFF_REF_PORT))
        ref_port_cfg <= hwdata[5:0];
      if (is_wr(wr_en, dph_addr, `SAS_OFF_TIMING))
        timing_cfg <= hwdata[7:0] & `SAS_TIMING_MASK;
      if (is_wr(wr_en, dph_addr, `SAS_OFF_IRQ))
        conv_done_irq_enable <= hwdata[`SAS_IRQ_EN_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Go/done bit.

  // Go can only be set while the converter is already on, so setting it
  // in the same write that turns the converter on does nothing.
  always @(posedge sys_clk)
  begin
    if (rst)
      go_done <= 1'b0;
    else if (is_wr(wr_en, dph_addr, `SAS_OFF_CTRL))
      go_done <= hwdata[`SAS_CTRL_GO_BIT] && converter_on
                 && hwdata[`SAS_CTRL_ON_BIT];
    else if (!converter_on || done_evt)
      go_done <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Conversion bit-period generator.

  // The divider only runs while a sequence is active, so the RC start
  // delay is seen again on every start.
  assign seq_run = converter_on && (state != ST_IDLE);

  sas_tad_gen u_tad_gen
  (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .run      (seq_run),
    .clk_sel  (conv_clock_select),
    .rc_tick  (rc_tick),
    .tad_tick (tad_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer state machine.

  // Software clearing go, or switching the converter off, ends the run.
  assign abort    = !go_done || !converter_on;
  assign done_evt = (state == ST_CONV) && tad_tick && !abort
                    && (conv_cnt == `SAS_CONV_PERIODS - 4'd1);
  assign bit_pos  = 4'd10 - conv_cnt;

  // Next-state logic; acquisition and conversion look alike to software.
  always @*
  begin
    next_state = state;
    case (state)
      ST_IDLE:
      begin
        if (converter_on && go_done)
        begin
          if (acq_periods == 5'd0)
            next_state = ST_CONV;
          else
            next_state = ST_ACQ;
        end
      end
      ST_ACQ:
      begin
        if (!converter_on)
          next_state = ST_IDLE;
        else if (abort)
          next_state = ST_GAP;
        else if (tad_tick && (period_cnt + 5'd1 == acq_periods))
          next_state = ST_CONV;
      end
      ST_CONV:
      begin
        if (!converter_on)
          next_state = ST_IDLE;
        else if (abort || done_evt)
          next_state = ST_GAP;
      end
      ST_GAP:
      begin
        if (!converter_on)
          next_state = ST_IDLE;
        else if (tad_tick &&
                 (period_cnt + 5'd1 == {3'b000, `SAS_GAP_PERIODS}))
          next_state = ST_IDLE;
      end
      default:
        next_state = ST_IDLE;
    endcase
  end

  // State, period counters and the approximation register.
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      state      <= ST_IDLE;
      period_cnt <= 5'd0;
      conv_cnt   <= 4'd0;
      sar        <= 10'h000;
    end
    else
    begin
      state <= next_state;
      if (next_state != state)
      begin
        period_cnt <= 5'd0;
        conv_cnt   <= 4'd0;
        if (next_state == ST_CONV)
          sar <= 10'h000;
      end
      else if (tad_tick)
      begin
        period_cnt <= period_cnt + 5'd1;
        if (state == ST_CONV)
        begin
          conv_cnt <= conv_cnt + 4'd1;
          // First period places the MSB trial, then one decision per
          // period, each but the last setting the next lower trial bit.
          if (conv_cnt == 4'd0)
            sar[9] <= 1'b1;
          else
          begin
            sar[bit_pos] <= comp_in;
            if (bit_pos != 4'd0)
              sar[bit_pos - 4'd1] <= 1'b1;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Result pair.

  // No reset: the pair keeps its contents across reset. An abort leaves
  // it alone, and software may also write it.
  always @(posedge sys_clk)
  begin
    if (done_evt)
    begin
      if (result_justify)
      begin
        result_high <= {6'b000000, sar[9:8]};
        result_low  <= {sar[7:1], comp_in};
      end
      else
      begin
        result_high <= sar[9:2];
        result_low  <= {sar[1], comp_in, 6'b000000};
      end
    end
    else
    begin
      if (is_wr(wr_en, dph_addr, `SAS_OFF_RES_HIGH))
        result_high <= hwdata[7:0];
      if (is_wr(wr_en, dph_addr, `SAS_OFF_RES_LOW))
        result_low <= hwdata[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Completion flag and request.

  // Completion wins over a clear written in the same cycle, so no
  // completion is ever lost.
  always @(posedge sys_clk)
  begin
    if (rst)
      conv_done_irq_flag <= 1'b0;
    else if (done_evt)
      conv_done_irq_flag <= 1'b1;
    else if (is_wr(wr_en, dph_addr, `SAS_OFF_IRQ) &&
             !hwdata[`SAS_IRQ_FLAG_BIT])
      conv_done_irq_flag <= 1'b0;
  end

  assign conv_irq = conv_done_irq_flag && conv_done_irq_enable;

  ////////////////////////////////////////////////////////////////////////////
  // Analog side controls.

  // The hold capacitor tracks the input while the converter is on, except during conversion.
  assign sample_connect = converter_on && (state != ST_CONV);
  assign dac_code       = sar;
  assign chan_sel       = channel_select;
  assign chan_valid     = (channel_select < `SAS_NUM_CHANNELS);
  assign neg_ref_ext    = ref_port_cfg[`SAS_NEG_REF_BIT];
  assign pos_ref_ext    = ref_port_cfg[`SAS_POS_REF_BIT];

  // Pin i is analog while i plus the code stays below fifteen, which
  // keeps codes 0 to 3 all analog and drops the top pin first.
  genvar gi;
  generate
    for (gi = 0; gi < 12; gi = gi + 1)
    begin : g_pin
      localparam [4:0] PIN = gi;
      assign analog_pin_mask[gi] =
        ({1'b0, port_analog_config} + PIN) < 5'd15;
    end
  endgenerate

endmodule

// >>> rtl/sas_tad_gen.v
// Conversion bit-period tick generator for the converter sequencer.
`include "sas_consts.vh"

module sas_tad_gen
(
  input  wire       sys_clk,
  input  wire       rst,
  input  wire       run,
  input  wire [2:0] clk_sel,
  input  wire       rc_tick,
  output reg        tad_tick
);

  reg [6:0] div_cnt;
  reg [2:0] rc_delay;
  wire      use_rc;

  // Divide ratio minus one for each system clock option.
  function [6:0] div_last;
    input [2:0] sel;
    begin
      case (sel)
        3'b000:  div_last = 7'd1;
        3'b001:  div_last = 7'd7;
        3'b010:  div_last = 7'd31;
        3'b100:  div_last = 7'd3;
        3'b101:  div_last = 7'd15;
        3'b110:  div_last = 7'd63;
        default: div_last = 7'd1;
      endcase
    end
  endfunction

  assign use_rc = (clk_sel[1:0] == 2'b11);

  // The divider restarts with each run so every period is whole.
  // A select change mid-run is tolerated by the >= compare.
  always @(posedge sys_clk)
  begin
    if (rst || !run)
    begin
      div_cnt  <= 7'd0;
      rc_delay <= 3'd0;
      tad_tick <= 1'b0;
    end
    else if (use_rc)
    begin
      // RC ticks are held off one instruction cycle.
      if (rc_delay != `SAS_TCY_CLOCKS)
      begin
        rc_delay <= rc_delay + 3'd1;
        tad_tick <= 1'b0;
      end
      else
      begin
        tad_tick <= rc_tick;
      end
    end
    else if (div_cnt >= div_last(clk_sel))
    begin
      div_cnt  <= 7'd0;
      tad_tick <= 1'b1;
    end
    else
    begin
      div_cnt  <= div_cnt + 7'd1;
      tad_tick <= 1'b0;
    end
  end

endmodule
